// ===== core/codec_ctrl_pkg.sv
// Constants, field layouts and carrier types for the codec control
// registers one to three. Shared by the register bank and the testbench.
package codec_ctrl_pkg;

    // Register addresses carried in the control word
    localparam logic [2:0] REG_CTRL1 = 3'h1;
    localparam logic [2:0] REG_CTRL2 = 3'h2;
    localparam logic [2:0] REG_CTRL3 = 3'h3;

    // Control register one field positions
    localparam int C1_ADC_OVF   = 7;
    localparam int C1_CONT      = 6;
    localparam int C1_IIR       = 5;
    localparam int C1_DAC_OVF   = 4;
    localparam int C1_BIAS      = 3;
    localparam int C1_ALB       = 2;
    localparam int C1_DLB       = 1;
    localparam int C1_DAC_FULL_WIDTH_FORMAT     = 0;

    // Control register two field positions
    localparam int C2_TURBO     = 7;
    localparam int C2_BYPASS    = 6;
    localparam int C2_ADDR_HI   = 5;
    localparam int C2_ADDR_LO   = 3;
    localparam int C2_GPO       = 2;
    localparam int C2_HPC_HI    = 1;
    localparam int C2_HPC_LO    = 0;

    // Control register three field positions
    localparam int C3_POWER_DOWN_SELECT_HI   = 7;
    localparam int C3_POWER_DOWN_SELECT_LO   = 6;
    localparam int C3_SOFTWARE_RESET_BIT      = 5;
    localparam int C3_OSR_HI    = 4;
    localparam int C3_OSR_LO    = 3;
    localparam int C3_RATIO_HI  = 2;
    localparam int C3_RATIO_LO  = 0;

    // Reset values
    localparam logic [7:0] CTRL1_RESET = 8'h00;
    localparam logic [7:0] CTRL2_RESET = 8'h20;
    localparam logic [7:0] CTRL3_RESET = 8'h01;

    // Host-port configurations
    localparam logic [1:0] HPC_I2C     = 2'h0;
    localparam logic [1:0] HPC_ALT     = 2'h1;
    localparam logic [1:0] HPC_GPO     = 2'h2;
    localparam logic [1:0] HPC_FLAG    = 2'h3;

    // Power-down codes
    localparam logic [1:0] POWER_DOWN_SELECT_NONE   = 2'h0;
    localparam logic [1:0] POWER_DOWN_SELECT_ADC    = 2'h1;
    localparam logic [1:0] POWER_DOWN_SELECT_DAC    = 2'h2;
    localparam logic [1:0] POWER_DOWN_SELECT_ALL    = 2'h3;

    // Oversampling ratios
    localparam logic [9:0] OSR_512     = 10'h200;
    localparam logic [9:0] OSR_256     = 10'h100;
    localparam logic [9:0] OSR_128     = 10'h080;
    localparam logic [3:0] RATIO_EIGHT = 4'h8;

    // Software reset delay, in master clocks after the frame sync fall
    localparam int         SWRESET_DELAY_MCLK = 6;

    // Control-frame word: address, read flag, broadcast, fill, data
    typedef struct packed {
        logic [2:0] addr;
        logic       read;
        logic       broadcast;
        logic [2:0] fill;
        logic [7:0] data;
    } cmd_type;

    // Decoded controls presented to the codec core
    typedef struct packed {
        logic       continuousMode;
        logic       iirSelect;
        logic       biasLevelSelect;
        logic       analogLoopbackEnable;
        logic       digitalLoopbackEnable;
        logic       dacFullWidthFormat;
        logic       turboMode;
        logic       filterBypass;
        logic       alternateTwoWireProtocol;
        logic       adcPowerDown;
        logic       dacPowerDown;
        logic [9:0] oversampleRatio;
        logic [3:0] sampleRateRatio;
    } ctrl_out_type;

endpackage : codec_ctrl_pkg

// ===== core/sync_two_flop.sv
// Two-flop synchroniser for a level arriving from outside the clock.
// Assumes the input changes slowly compared with clk.
`timescale 1ns/1ns
`default_nettype none
module sync_two_flop (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic asyncIn,
    output var  logic syncOut
);
    logic firstStage;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            firstStage <= 1'b0;
            syncOut    <= 1'b0;
        end else if (ce) begin
            firstStage <= asyncIn;
            syncOut    <= firstStage;
        end
    end
endmodule : sync_two_flop
`default_nettype wire

// ===== core/sticky_flag.sv
// Sticky event flag: set by hardware, cleared by a read or reset.
// A set in the same cycle as a clear wins, so no event is lost.
`timescale 1ns/1ns
`default_nettype none
module sticky_flag (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    input  wire logic set,
    input  wire logic clear,
    output var  logic flag
);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (ce) begin
            flag <= set | (flag & ~clear);
        end
    end
endmodule : sticky_flag
`default_nettype wire

// ===== core/codec_control_regs.sv
// Control registers one to three of the voice codec, with the decoding
// of their fields. Commands arrive as decoded control-frame words from
// the serial port logic on the same clock; clk is the master clock.
`timescale 1ns/1ns
`default_nettype none
//
// Operation
// [R01] Read-only ADC overflow flag in register one D7
// [R02] D6 selects programming or continuous transfer
// [R03] D5 selects FIR or IIR filter
// [R04] Read-only DAC overflow flag in D4
// [R05] D3 drives the bias level select
// [R06] D2 enables analog loopback
// [R07] D1 enables digital loopback
// [R08] D0 sets DAC word width, continuous only
// [R09] Set DAC LSB leaves continuous mode; here only in 15+1 format, D0 clear
// [R10] Register two D7 selects bit clock mode
// [R11] D6 bypasses both decimation and interpolation filters
// [R12] D5-D3 give host address top bits
// [R13] D2 drives data pin when configuration 10
// [R14] D1-D0 configure the two-wire pins
// [R15] Register three D7-D6 decode power-down
// [R16] Writing D5 triggers a software reset
// [R17] D4-D3 choose DAC oversampling ratio
// [R18] D2-D0 give frame to sample ratio
// [R19] Writes apply next frame sync; reset delayed
// [R20] Control word: address, read flag, data byte
// [R21] Writes to overflow flags are ignored
module codec_control_regs (
    input  wire logic                         clk,
    input  wire logic                         nrst,
    input  wire logic                         ce,
    input  wire logic                         frameSyncPin,
    input  wire logic                         cmdValid,
    input  wire codec_ctrl_pkg::cmd_type      cmd,
    input  wire logic [3:0]                   cascadeAddr,
    input  wire logic                         adcOverflow,
    input  wire logic                         dacOverflow,
    input  wire logic                         dacWordValid,
    input  wire logic [15:0]                  dacWord,
    input  wire logic                         sclPin,
    input  wire logic                         controlFrameFlag,
    output var  logic                         readValid,
    output var  logic [7:0]                   readData,
    output var  codec_ctrl_pkg::ctrl_out_type ctrl,
    output var  logic [6:0]                   hostAddress,
    output var  logic                         sdaOut,
    output var  logic                         sdaOe_n,
    output var  logic                         sclToDout,
    output var  logic                         routeSclToDout,
    output var  logic                         softReset
);
    import codec_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisation and frame sync edges
    // ------------------------------------------------------------
    logic frameSync;
    logic frameSyncLast;
    logic sclSync;
    wire  fsRise = frameSync & ~frameSyncLast;
    wire  fsFall = ~frameSync & frameSyncLast;

    sync_two_flop fsSync (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .asyncIn (frameSyncPin),
        .syncOut (frameSync)
    );

    sync_two_flop sclSyncer (
        .clk     (clk),
        .nrst    (nrst),
        .ce      (ce),
        .asyncIn (sclPin),
        .syncOut (sclSync)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            frameSyncLast <= 1'b0;
        end else if (ce) begin
            frameSyncLast <= frameSync;
        end
    end

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire isRead  = cmdValid & cmd.read;                          // R20
    wire isWrite = cmdValid & ~cmd.read;                         // R20
    wire wr1     = isWrite & (cmd.addr == REG_CTRL1);
    wire wr2     = isWrite & (cmd.addr == REG_CTRL2);
    wire wr3     = isWrite & (cmd.addr == REG_CTRL3);
    wire rd1     = isRead & (cmd.addr == REG_CTRL1);

    // ------------------------------------------------------------
    // Staged writes, applied on the next frame sync
    // ------------------------------------------------------------
    // A write landing on the apply edge waits for the following sync,
    // so a late write never lands half way through a frame.
    logic [7:0] ctrl1;
    logic [7:0] ctrl2;
    logic [7:0] ctrl3;
    logic [7:0] pend1;
    logic [7:0] pend2;
    logic [7:0] pend3;
    logic [2:0] pendValid;
    logic       adcOvfFlag;
    logic       dacOvfFlag;

    wire apply1 = fsRise & pendValid[0];                         // R19
    wire apply2 = fsRise & pendValid[1];                         // R19
    wire apply3 = fsRise & pendValid[2];                         // R19

    wire contExit = ctrl1[C1_CONT] & ~ctrl1[C1_DAC_FULL_WIDTH_FORMAT]
                  & dacWordValid & dacWord[0];                   // R09

    typedef enum {SR_IDLE, SR_ARMED, SR_COUNT} swreset_type;
    swreset_type srState;
    swreset_type next_srState;
    logic [2:0]  srCount;
    localparam logic [2:0] SR_LAST = 3'(SWRESET_DELAY_MCLK - 1);
    wire srArm = apply3 & pend3[C3_SOFTWARE_RESET_BIT];                        // R16

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pend1     <= CTRL1_RESET;
            pend2     <= CTRL2_RESET;
            pend3     <= CTRL3_RESET;
            pendValid <= 3'h0;
        end else if (ce) begin
            if (softReset) begin
                pendValid <= 3'h0;
            end else begin
                pendValid[0] <= wr1 | (pendValid[0] & ~fsRise);
                pendValid[1] <= wr2 | (pendValid[1] & ~fsRise);
                pendValid[2] <= wr3 | (pendValid[2] & ~fsRise);
            end
            if (wr1) begin
                pend1 <= cmd.data;
            end
            if (wr2) begin
                pend2 <= cmd.data;
            end
            if (wr3) begin
                pend3 <= cmd.data;
            end
        end
    end

    // Overflow bits are never stored from a write; only the sources
    // set them, and a read of register one clears them.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl1 <= CTRL1_RESET;
            ctrl2 <= CTRL2_RESET;
            ctrl3 <= CTRL3_RESET;
        end else if (ce) begin
            if (softReset) begin
                ctrl1 <= CTRL1_RESET;
                ctrl2 <= CTRL2_RESET;
                ctrl3 <= CTRL3_RESET;
            end else begin
                if (apply1) begin
                    ctrl1 <= pend1 & 8'h6f;                      // R21
                end else if (contExit) begin
                    ctrl1[C1_CONT] <= 1'b0;                      // R09
                end
                if (apply2) begin
                    ctrl2 <= pend2;
                end
                if (apply3) begin
                    ctrl3 <= pend3;
                end
            end
        end
    end

    sticky_flag adcOvf (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .set   (adcOverflow),                                    // R01
        .clear (rd1 | softReset),
        .flag  (adcOvfFlag)
    );

    sticky_flag dacOvf (
        .clk   (clk),
        .nrst  (nrst),
        .ce    (ce),
        .set   (dacOverflow),                                    // R04
        .clear (rd1 | softReset),
        .flag  (dacOvfFlag)
    );

    // ------------------------------------------------------------
    // Software reset sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_srState = srState;
        case (srState)
            SR_IDLE:  if (srArm) next_srState = SR_ARMED;
            SR_ARMED: if (fsFall) next_srState = SR_COUNT;       // R19
            SR_COUNT: if (srCount == SR_LAST) next_srState = SR_IDLE;
            default:  next_srState = SR_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srState <= SR_IDLE;
            srCount <= 3'h0;
        end else if (ce) begin
            srState <= next_srState;
            srCount <= (srState == SR_COUNT) ? srCount + 3'h1 : 3'h0;
        end
    end

    assign softReset = (srState == SR_COUNT) & (srCount == SR_LAST); // R16

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    wire [7:0] view1 = {adcOvfFlag, ctrl1[6:5], dacOvfFlag,
                        ctrl1[3:0]};                             // R01 R04
    wire [7:0] view3 = {ctrl3[7:6], srState != SR_IDLE, ctrl3[4:0]};
    wire [7:0] readMux = (cmd.addr == REG_CTRL1) ? view1 :
                         (cmd.addr == REG_CTRL2) ? ctrl2 :
                         (cmd.addr == REG_CTRL3) ? view3 : 8'h00;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readValid <= 1'b0;
            readData  <= 8'h00;
        end else if (ce) begin
            readValid <= isRead;                                 // R20
            if (isRead) begin
                readData <= readMux;
            end
        end
    end

    // ------------------------------------------------------------
    // Field decoding
    // ------------------------------------------------------------
    wire [1:0] host_port_config  = ctrl2[C2_HPC_HI:C2_HPC_LO];
    wire [1:0] power_down_select = ctrl3[C3_POWER_DOWN_SELECT_HI:C3_POWER_DOWN_SELECT_LO];
    wire [1:0] osr  = ctrl3[C3_OSR_HI:C3_OSR_LO];
    wire [2:0] sample_rate_ratio = ctrl3[C3_RATIO_HI:C3_RATIO_LO];

    assign ctrl.continuousMode        = ctrl1[C1_CONT];          // R02
    assign ctrl.iirSelect             = ctrl1[C1_IIR];           // R03
    assign ctrl.biasLevelSelect       = ctrl1[C1_BIAS];          // R05
    assign ctrl.analogLoopbackEnable  = ctrl1[C1_ALB];           // R06
    assign ctrl.digitalLoopbackEnable = ctrl1[C1_DLB];           // R07
    assign ctrl.dacFullWidthFormat    = ctrl1[C1_CONT]
                                      & ctrl1[C1_DAC_FULL_WIDTH_FORMAT];         // R08
    assign ctrl.turboMode             = ctrl2[C2_TURBO];         // R10
    assign ctrl.filterBypass          = ctrl2[C2_BYPASS];        // R11
    assign ctrl.alternateTwoWireProtocol = (host_port_config == HPC_ALT);     // R14
    assign ctrl.adcPowerDown = (power_down_select == POWER_DOWN_SELECT_ADC)
                             | (power_down_select == POWER_DOWN_SELECT_ALL);               // R15
    assign ctrl.dacPowerDown = (power_down_select == POWER_DOWN_SELECT_DAC)
                             | (power_down_select == POWER_DOWN_SELECT_ALL);               // R15
    assign ctrl.oversampleRatio = osr[0] ? OSR_512 :
                                  osr[1] ? OSR_256 : OSR_128;    // R17
    assign ctrl.sampleRateRatio = (sample_rate_ratio == 3'h0) ? RATIO_EIGHT
                                                 : {1'b0, sample_rate_ratio}; // R18

    assign hostAddress = {ctrl2[C2_ADDR_HI:C2_ADDR_LO],
                          cascadeAddr};                          // R12

    // Data pin is released in the two-wire modes; the protocol engine
    // elsewhere owns it there.
    assign sdaOut = (host_port_config == HPC_GPO)  ? ctrl2[C2_GPO] :          // R13
                    (host_port_config == HPC_FLAG) ? controlFrameFlag : 1'b1; // R14
    assign sdaOe_n        = ~host_port_config[1];                             // R14
    assign routeSclToDout = (host_port_config == HPC_GPO);                    // R14
    assign sclToDout      = sclSync & routeSclToDout;            // R14

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_adc_flag_set: assert property ( // R01
        @(posedge clk) disable iff (!nrst || !ce)
        adcOverflow && !softReset |=> view1[C1_ADC_OVF])
        else $error("ADC overflow not reported");
    a_dac_flag_set: assert property ( // R04
        @(posedge clk) disable iff (!nrst || !ce)
        dacOverflow && !softReset |=> view1[C1_DAC_OVF])
        else $error("DAC overflow not reported");
    a_write_on_sync: assert property ( // R19
        @(posedge clk) disable iff (!nrst || !ce)
        apply2 && !softReset |=> ctrl2 == $past(pend2))
        else $error("Staged write not applied on frame sync");
    a_write_waits: assert property ( // R19
        @(posedge clk) disable iff (!nrst || !ce)
        !fsRise && !softReset |=> $stable(ctrl2))
        else $error("Register changed between frame syncs");
    a_reset_delay: assert property ( // R16
        @(posedge clk) disable iff (!nrst || !ce)
        srState == SR_ARMED && fsFall |-> !softReset [*6] ##1 softReset)
        else $error("Software reset not six clocks after sync fall");
    a_cont_exit: assert property ( // R09
        @(posedge clk) disable iff (!nrst || !ce)
        contExit && !apply1 |=> !ctrl.continuousMode)
        else $error("Flagged DAC word did not leave continuous mode");
    a_read_answer: assert property ( // R20
        @(posedge clk) disable iff (!nrst || !ce)
        isRead && cmd.addr == REG_CTRL2
        |=> readValid && readData == $past(ctrl2))
        else $error("Register read returned wrong data");
    a_sda_general: assert property ( // R13
        @(posedge clk) disable iff (!nrst)
        host_port_config == HPC_GPO |-> !sdaOe_n && sdaOut == ctrl2[C2_GPO])
        else $error("Data pin not driven from output bit");
    a_full_power: assert property ( // R15
        @(posedge clk) disable iff (!nrst)
        power_down_select == POWER_DOWN_SELECT_ALL |-> ctrl.adcPowerDown && ctrl.dacPowerDown)
        else $error("Full power-down not decoded");
    a_ratio_eight: assert property ( // R18
        @(posedge clk) disable iff (!nrst)
        sample_rate_ratio == 3'h0 |-> ctrl.sampleRateRatio == RATIO_EIGHT)
        else $error("Ratio code zero not decoded as eight");
    a_osr_select: assert property ( // R17
        @(posedge clk) disable iff (!nrst)
        osr == 2'h2 |-> ctrl.oversampleRatio == OSR_256)
        else $error("Oversampling ratio decode wrong");

endmodule : codec_control_regs
`default_nettype wire

// ===== testbench/dsp_port_model.sv
// Host-side model: free-running frame sync and control-word access tasks.
// Assumes one bench process calls the tasks, and clk is the master clock.
`timescale 1ns/1ns
`default_nettype none
module dsp_port_model (
    input  wire logic                    clk,
    input  wire logic                    readValid,
    input  wire logic [7:0]              readData,
    output var  logic                    frameSyncPin,
    output var  logic                    cmdValid,
    output var  codec_ctrl_pkg::cmd_type cmd,
    output var  logic                    dacWordValid,
    output var  logic [15:0]             dacWord
);
    import codec_ctrl_pkg::*;

    // ------------------------------------------------------------
    // Frame sync source, 32 clocks a frame, high for two
    // ------------------------------------------------------------
    logic [4:0] frameCount = 5'h00;

    always_ff @(posedge clk) begin
        frameCount <= frameCount + 5'h01;
    end
    assign frameSyncPin = (frameCount < 5'h02);

    initial begin
        cmdValid     = 1'b0;
        cmd          = '0;
        dacWordValid = 1'b0;
        dacWord      = 16'h0000;
    end

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    // Data is inverted once taken so a stale word is never mistaken
    task automatic send(input logic [2:0] a, input logic rd,
                        input logic [7:0] data);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmd      <= '{addr: a, read: rd, broadcast: 1'b0,
                      fill: 3'h7, data: data};
        @(posedge clk);
        cmdValid <= 1'b0;
        cmd.data <= ~data;
    endtask : send

    task automatic write_reg(input logic [2:0] a, input logic [7:0] data);
        send(a, 1'b0, data);
    endtask : write_reg

    task automatic read_reg(input logic [2:0] a, output logic [7:0] d,
                            output logic v);
        send(a, 1'b1, 8'h00);
        #1;
        v = readValid;
        d = readData;
    endtask : read_reg

    // A write lands within a few clocks of the next frame sync rise
    task automatic wait_apply();
        @(posedge frameSyncPin);
        repeat (4) @(posedge clk);
    endtask : wait_apply

    task automatic dac_word(input logic [15:0] w);
        @(posedge clk);
        dacWordValid <= 1'b1;
        dacWord      <= w;
        @(posedge clk);
        dacWordValid <= 1'b0;
        dacWord      <= ~w;
    endtask : dac_word

endmodule : dsp_port_model
`default_nettype wire

// ===== testbench/test_codec_control_regs.sv
// Self-checking bench for the codec control registers one to three.
// Assumes the host model above supplies frame sync and control words.
`timescale 1ns/1ns
`default_nettype none
module test_codec_control_regs;
    import codec_ctrl_pkg::*;

    logic clk, nrst, ce, adcOverflow, dacOverflow, sclPin, controlFrameFlag;
    logic [3:0]   cascadeAddr;
    logic         frameSyncPin, cmdValid, dacWordValid, readValid;
    logic [15:0]  dacWord;
    logic [7:0]   readData;
    logic [6:0]   hostAddress;
    logic         sdaOut, sdaOe_n, sclToDout, routeSclToDout, softReset;
    cmd_type      cmd;
    ctrl_out_type ctrl;
    int           nMismatch = 0;
    int           numChecks = 0;
    int           cycles    = 0;

    codec_control_regs i_codec_control_regs (
        .clk(clk), .nrst(nrst), .ce(ce), .frameSyncPin(frameSyncPin),
        .cmdValid(cmdValid), .cmd(cmd), .cascadeAddr(cascadeAddr),
        .adcOverflow(adcOverflow), .dacOverflow(dacOverflow),
        .dacWordValid(dacWordValid), .dacWord(dacWord), .sclPin(sclPin),
        .controlFrameFlag(controlFrameFlag), .readValid(readValid),
        .readData(readData), .ctrl(ctrl), .hostAddress(hostAddress),
        .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .sclToDout(sclToDout),
        .routeSclToDout(routeSclToDout), .softReset(softReset));

    dsp_port_model i_dsp_port_model (
        .clk(clk), .readValid(readValid), .readData(readData),
        .frameSyncPin(frameSyncPin), .cmdValid(cmdValid), .cmd(cmd),
        .dacWordValid(dacWordValid), .dacWord(dacWord));

    // ------------------------------------------------------------
    // Clock, timeout and reporting
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Whole run needs under a thousand clocks; this bound catches hangs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nMismatch++;
            conclude();
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic       v;
        i_dsp_port_model.read_reg(a, d, v);
        check(16'(v), 16'h0001);
        check(16'(d), 16'(exp));
    endtask : rd

    task automatic wr(input logic [2:0] a, input logic [7:0] data);
        i_dsp_port_model.write_reg(a, data);
        i_dsp_port_model.wait_apply();
    endtask : wr

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    logic [7:0] v1 [5] = '{8'h20, 8'h08, 8'h04, 8'h02, 8'h90};
    logic [7:0] val;
    logic [1:0] c;
    int         n;

    initial begin
        nrst = 1'b0; ce = 1'b1; adcOverflow = 1'b0; dacOverflow = 1'b0;
        sclPin = 1'b1; controlFrameFlag = 1'b0; cascadeAddr = 4'h9;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h20);
        rd(3'h3, 8'h01);
        check(16'(ctrl.oversampleRatio), 16'h0080);
        check(16'(ctrl.sampleRateRatio), 16'h0001);
        // Register one fields, last entry aims at the read-only flags
        for (int i = 0; i < 5; i++) begin
            wr(3'h1, v1[i]);
            check(16'({ctrl.iirSelect, ctrl.biasLevelSelect,
                       ctrl.analogLoopbackEnable, ctrl.digitalLoopbackEnable}),
                  16'({v1[i][5], v1[i][3], v1[i][2], v1[i][1]}));
            rd(3'h1, v1[i] & 8'h6f);
        end
        @(posedge clk) adcOverflow <= 1'b1;
        @(posedge clk) adcOverflow <= 1'b0;
        rd(3'h1, 8'h80);
        rd(3'h1, 8'h00);
        @(posedge clk) dacOverflow <= 1'b1;
        @(posedge clk) dacOverflow <= 1'b0;
        rd(3'h1, 8'h10);
        // Continuous mode, 15+1 format, then 16-bit format
        wr(3'h1, 8'h40);
        check(16'(ctrl.continuousMode), 16'h0001);
        check(16'(ctrl.dacFullWidthFormat), 16'h0000);
        i_dsp_port_model.dac_word(16'h0001);
        #1 check(16'(ctrl.continuousMode), 16'h0000);
        wr(3'h1, 8'h41);
        check(16'(ctrl.dacFullWidthFormat), 16'h0001);
        i_dsp_port_model.dac_word(16'h0001);
        #1 check(16'(ctrl.continuousMode), 16'h0001);
        // Register two: every host-port configuration
        for (int i = 0; i < 4; i++) begin
            c   = 2'(i);
            val = {c[1], c[0], 3'(i + 3), c[0], c};
            wr(3'h2, val);
            check(16'({ctrl.turboMode, ctrl.filterBypass}),
                  16'(val[7:6]));
            check(16'(hostAddress), 16'({val[5:3], 4'h9}));
            check(16'(sdaOe_n), {15'h0, ~c[1]});
            if (c[1]) check(16'(sdaOut),
                            16'(c[0] ? controlFrameFlag : val[2]));
            check(16'({routeSclToDout, sclToDout}),
                  {14'h0, c == 2'h2, c == 2'h2});
            check(16'(ctrl.alternateTwoWireProtocol), 16'(c == 2'h1));
            // Clock pin must really follow through, not sit at its idle 1
            if (c == 2'h2) begin
                @(posedge clk) sclPin <= 1'b0;
                repeat (3) @(posedge clk);
                #1 check(16'(sclToDout), 16'h0000);
                @(posedge clk) sclPin <= 1'b1;
            end
            rd(3'h2, val);
        end
        // Register three: all power-down, oversampling and ratio codes
        for (int i = 0; i < 8; i++) begin
            c   = 2'(i);
            val = {c, 1'b0, c, 3'(i)};
            wr(3'h3, val);
            check(16'({ctrl.dacPowerDown, ctrl.adcPowerDown}), 16'(c));
            check(16'(ctrl.oversampleRatio),
                  c[0] ? 16'h0200 : (c[1] ? 16'h0100 : 16'h0080));
            check(16'(ctrl.sampleRateRatio),
                  (i == 0) ? 16'h0008 : 16'(i));
            rd(3'h3, val);
        end
        // Unmapped addresses read zero and keep register two intact
        wr(3'h5, 8'hff);
        rd(3'h5, 8'h00);
        rd(3'h2, 8'hf7);
        // Software reset, then every register back to its reset value
        i_dsp_port_model.write_reg(3'h3, 8'h21);
        n = 0;
        while (softReset !== 1'b1 && n < 300) begin
            @(posedge clk) #1;
            n++;
        end
        check(16'(softReset), 16'h0001);
        @(posedge clk) #1 check(16'(softReset), 16'h0000);
        rd(3'h1, 8'h00);
        rd(3'h2, 8'h20);
        rd(3'h3, 8'h01);
        conclude();
    end

endmodule : test_codec_control_regs
`default_nettype wire
